// File: hdl/tic_pkg.sv
package tic_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL1   = 8'h00;
   localparam logic [7:0] OFS_CTRL2   = 8'h04;
   localparam logic [7:0] OFS_STATUS  = 8'h08;
   localparam logic [7:0] OFS_COUNT   = 8'h0c;
   localparam logic [7:0] OFS_CAP_A   = 8'h10;
   localparam logic [7:0] OFS_CAP_B   = 8'h14;

   // Reset values
   localparam logic [15:0] CTRL1_RST  = 16'h0000;
   localparam logic [15:0] CTRL2_RST  = 16'h0000;
   localparam logic [15:0] STATUS_RST = 16'h0000;
   localparam logic [15:0] COUNT_RST  = 16'hfffc;
   localparam logic [15:0] CAP_RST    = 16'h0000;
   localparam logic [7:0]  PRESC_RST  = 8'h00;

   // Counter values
   localparam logic [15:0] COUNT_LOAD = 16'hfffc;
   localparam logic [15:0] COUNT_WRAP = 16'hffff;

   // First control register fields
   localparam int CR1_EXT_SEL  = 0;
   localparam int CR1_EXT_POL  = 1;
   localparam int CR1_EDGE_A   = 2;
   localparam int CR1_EDGE_B   = 3;
   localparam logic [15:0] CTRL1_MASK = 16'h000f;

   // Second control register fields; enables share the status layout
   localparam int CR2_PRESC_LSB = 0;
   localparam int CR2_DMA_EN    = 8;
   localparam int CR2_DMA_SEL   = 9;
   localparam logic [15:0] CTRL2_MASK = 16'hfbff;

   // Status flag positions
   localparam int SR_CAP_A  = 15;
   localparam int SR_CMP_A  = 14;
   localparam int SR_ROLL   = 13;
   localparam int SR_CAP_B  = 12;
   localparam int SR_CMP_B  = 11;
   localparam logic [15:0] SR_FLAGS = 16'hf800;

   // Bus answers
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// File: hdl/tic_edge_sync.sv
`timescale 1ns/1ps
module tic_edge_sync (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic pin,
   input  wire logic rise_sel,
   output wire logic edge_pulse
);
   logic meta_r;
   logic sync_r;
   logic last_r;

   // Two-stage synchroniser, then one stage for edge detection
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         last_r <= 1'b0;
      end else begin
         meta_r <= pin;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   assign edge_pulse = rise_sel ? (sync_r & ~last_r) : (~sync_r & last_r);
endmodule

// File: hdl/tic_prescaler.sv
`timescale 1ns/1ps
module tic_prescaler (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [7:0] factor,
   output wire logic       tick
);
   logic [7:0] div_r;

   // Divides by factor plus one; 0 gives a tick every cycle
   assign tick = (div_r >= factor);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_r <= tic_pkg::PRESC_RST;
      end else if (tick) begin
         div_r <= tic_pkg::PRESC_RST;
      end else begin
         div_r <= div_r + 8'h01;
      end
   end
endmodule

// File: hdl/tic_timer.sv
// How it works
// - Any write to the counter register loads FFFCh, data ignored.
// - Select bit 0 counts prescaled clock ticks; 1 counts external clock edges.
// - Prescaler divides the system clock by factor plus one, 1 to 256.
// - Counter wrap from FFFFh to 0000h sets the rollover flag.
// - Rollover flag raises interrupt while enabled; stays pending until enabled.
// - Status write with 0 in bit 13 clears rollover; 1 leaves it.
// - External clock comes from reference clock or capture pin A, per config.
// - Polarity bit picks the external clock transition that counts.
// - All counter updates happen on the system clock rising edge.
// - Each capture channel latches the counter on its active pin transition.
// - Capture value registers are read-only; writes leave them unchanged.
// - Per-channel edge bit picks rising or falling capture transition.
// - Capture sets its flag; interrupt while enabled, else pending.
// - Status write with 0 in bit 15 or 12 clears capture A or B.
// - DMA acknowledge clears the selected capture flag when DMA is enabled.
// - One interrupt output ORs capture A, B and rollover; no logic sets the compare flags.
`timescale 1ns/1ps
module tic_timer (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output wire logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output wire logic        s_axi_wready,
   output wire logic [1:0]  s_axi_bresp,
   output wire logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output wire logic        s_axi_arready,
   output wire logic [31:0] s_axi_rdata,
   output wire logic [1:0]  s_axi_rresp,
   output wire logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        ext_clock_input,
   input  wire logic        timer_source_config,
   input  wire logic        capture_pin_a,
   input  wire logic        capture_pin_b,
   input  wire logic        dma_ack,
   output wire logic        timer_irq
);

   // Lane merge for byte strobes
   function automatic logic [15:0] strb_merge(
      input logic [15:0] old_val,
      input logic [31:0] new_val,
      input logic [3:0]  strb
   );
      logic [15:0] res;
      res = old_val;
      if (strb[0]) begin
         res[7:0] = new_val[7:0];
      end
      if (strb[1]) begin
         res[15:8] = new_val[15:8];
      end
      return res;
   endfunction

   // Register offset match on the whole address: low byte equals the offset, upper 24 bits zero
   function automatic logic addr_is(
      input logic [31:0] addr,
      input logic [7:0]  ofs
   );
      return (addr[7:0] == ofs) && (addr[31:8] == 24'h000000);
   endfunction

   // Bus slave state
   logic        awready_r;
   logic        wready_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        aw_have_r;
   logic        w_have_r;
   logic [31:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        arready_r;
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;

   // Timer state
   logic [15:0] ctrl1_r;
   logic [15:0] ctrl2_r;
   logic [15:0] ctrl2_nxt;
   logic [15:0] status_r;
   logic [15:0] status_nxt;
   logic [15:0] count_r;
   logic [15:0] cap_a_r;
   logic [15:0] cap_b_r;
   logic        irq_r;
   logic        irq_nxt;

   // Write decode
   wire wr_go     = aw_have_r & w_have_r & ~bvalid_r;
   wire wr_ctrl1  = wr_go & addr_is(awaddr_r, tic_pkg::OFS_CTRL1);
   wire wr_ctrl2  = wr_go & addr_is(awaddr_r, tic_pkg::OFS_CTRL2);
   wire wr_status = wr_go & addr_is(awaddr_r, tic_pkg::OFS_STATUS);
   wire wr_count  = wr_go & addr_is(awaddr_r, tic_pkg::OFS_COUNT);
   wire wr_cap_a  = wr_go & addr_is(awaddr_r, tic_pkg::OFS_CAP_A);
   wire wr_cap_b  = wr_go & addr_is(awaddr_r, tic_pkg::OFS_CAP_B);
   wire wr_known  = wr_ctrl1 | wr_ctrl2 | wr_status | wr_count
                  | wr_cap_a | wr_cap_b;

   // Read decode
   wire rd_go     = s_axi_arvalid & arready_r;
   wire rd_ctrl1  = addr_is(s_axi_araddr, tic_pkg::OFS_CTRL1);
   wire rd_ctrl2  = addr_is(s_axi_araddr, tic_pkg::OFS_CTRL2);
   wire rd_status = addr_is(s_axi_araddr, tic_pkg::OFS_STATUS);
   wire rd_count  = addr_is(s_axi_araddr, tic_pkg::OFS_COUNT);
   wire rd_cap_a  = addr_is(s_axi_araddr, tic_pkg::OFS_CAP_A);
   wire rd_cap_b  = addr_is(s_axi_araddr, tic_pkg::OFS_CAP_B);
   wire rd_known  = rd_ctrl1 | rd_ctrl2 | rd_status | rd_count
                  | rd_cap_a | rd_cap_b;
   wire [15:0] rd_val =
        rd_ctrl1  ? ctrl1_r  :
        rd_ctrl2  ? ctrl2_r  :
        rd_status ? status_r :
        rd_count  ? count_r  :
        rd_cap_a  ? cap_a_r  :
        rd_cap_b  ? cap_b_r  : 16'h0000;

   // Control fields
   wire       ext_sel  = ctrl1_r[tic_pkg::CR1_EXT_SEL];
   wire       ext_pol  = ctrl1_r[tic_pkg::CR1_EXT_POL];
   wire       edge_a   = ctrl1_r[tic_pkg::CR1_EDGE_A];
   wire       edge_b   = ctrl1_r[tic_pkg::CR1_EDGE_B];
   wire [7:0] presc    = ctrl2_r[tic_pkg::CR2_PRESC_LSB +: 8];
   wire       dma_en   = ctrl2_r[tic_pkg::CR2_DMA_EN];
   wire       dma_sel  = ctrl2_r[tic_pkg::CR2_DMA_SEL];

   wire ext_edge;
   wire ref_edge;
   wire pin_a_ext_edge;
   wire presc_tick;
   wire cap_a_edge;
   wire cap_b_edge;

   tic_edge_sync u_ext_sync (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .pin        (ext_clock_input),
      .rise_sel   (ext_pol),
      .edge_pulse (ref_edge)
   );

   // Capture pin A as external clock, clock polarity applies
   tic_edge_sync u_pin_a_ext_sync (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .pin        (capture_pin_a),
      .rise_sel   (ext_pol),
      .edge_pulse (pin_a_ext_edge)
   );

   tic_edge_sync u_cap_a_sync (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .pin        (capture_pin_a),
      .rise_sel   (edge_a),
      .edge_pulse (cap_a_edge)
   );

   tic_edge_sync u_cap_b_sync (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .pin        (capture_pin_b),
      .rise_sel   (edge_b),
      .edge_pulse (cap_b_edge)
   );

   tic_prescaler u_presc (
      .aclk    (aclk),
      .aresetn (aresetn),
      .factor  (presc),
      .tick    (presc_tick)
   );

   // Source picked after synchronisation, so no pin reaches logic unsynchronised
   assign ext_edge = timer_source_config ? pin_a_ext_edge : ref_edge;

   // Counting tick and rollover
   wire count_tick = ext_sel ? ext_edge : presc_tick;
   wire rollover   = count_tick & ~wr_count & (count_r == tic_pkg::COUNT_WRAP);

   // Status set and clear terms
   logic [15:0] sr_set;
   logic [15:0] sr_clr;
   logic [15:0] wr_clr;
   logic [15:0] dma_clr;

   assign wr_clr = wr_status ? (~strb_merge(16'hffff, wdata_r, wstrb_r)
                                & tic_pkg::SR_FLAGS) : 16'h0000;

   always_comb begin
      dma_clr = 16'h0000;
      if (dma_ack && dma_en) begin
         if (dma_sel) begin
            dma_clr[tic_pkg::SR_CAP_B] = 1'b1;
         end else begin
            dma_clr[tic_pkg::SR_CAP_A] = 1'b1;
         end
      end
   end

   always_comb begin
      sr_set = 16'h0000;
      sr_set[tic_pkg::SR_ROLL]  = rollover;
      sr_set[tic_pkg::SR_CAP_A] = cap_a_edge;
      sr_set[tic_pkg::SR_CAP_B] = cap_b_edge;
   end

   // Mask update reaches the interrupt in the same cycle
   assign ctrl2_nxt = wr_ctrl2
                    ? (strb_merge(ctrl2_r, wdata_r, wstrb_r) & tic_pkg::CTRL2_MASK)
                    : ctrl2_r;

   assign sr_clr = wr_clr | dma_clr;
   // Set wins over a clear in the same cycle
   assign status_nxt = (status_r & ~sr_clr) | sr_set;
   // Enables in the second control register share the status layout
   assign irq_nxt = |(status_nxt & ctrl2_nxt & tic_pkg::SR_FLAGS);

   // Counter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_r <= tic_pkg::COUNT_RST;
      end else if (wr_count) begin
         count_r <= tic_pkg::COUNT_LOAD;
      end else if (count_tick) begin
         count_r <= count_r + 16'h0001;
      end
   end

   // Capture registers, not writable from the bus
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cap_a_r <= tic_pkg::CAP_RST;
         cap_b_r <= tic_pkg::CAP_RST;
      end else begin
         if (cap_a_edge) begin
            cap_a_r <= count_r;
         end
         if (cap_b_edge) begin
            cap_b_r <= count_r;
         end
      end
   end

   // Control, status and interrupt
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl1_r  <= tic_pkg::CTRL1_RST;
         ctrl2_r  <= tic_pkg::CTRL2_RST;
         status_r <= tic_pkg::STATUS_RST;
         irq_r    <= 1'b0;
      end else begin
         if (wr_ctrl1) begin
            ctrl1_r <= strb_merge(ctrl1_r, wdata_r, wstrb_r) & tic_pkg::CTRL1_MASK;
         end
         ctrl2_r  <= ctrl2_nxt;
         status_r <= status_nxt;
         irq_r    <= irq_nxt;
      end
   end

   // Write channels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         awaddr_r  <= 32'h00000000;
         wdata_r   <= 32'h00000000;
         wstrb_r   <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= tic_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && awready_r) begin
            awaddr_r  <= s_axi_awaddr;
            aw_have_r <= 1'b1;
            awready_r <= 1'b0;
         end
         if (s_axi_wvalid && wready_r) begin
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
            w_have_r <= 1'b1;
            wready_r <= 1'b0;
         end
         if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_known ? tic_pkg::RESP_OKAY : tic_pkg::RESP_SLVERR;
         end
         if (bvalid_r && s_axi_bready) begin
            bvalid_r  <= 1'b0;
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
         end
      end
   end

   // Read channels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h00000000;
         rresp_r   <= tic_pkg::RESP_OKAY;
      end else if (rd_go) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b1;
         rdata_r   <= {16'h0000, rd_val};
         rresp_r   <= rd_known ? tic_pkg::RESP_OKAY : tic_pkg::RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r  <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign timer_irq     = irq_r;

endmodule

// File: verif/tic_pins_model.sv
`timescale 1ns/1ps
module tic_pins_model (
   input  wire logic aclk,
   input  wire logic run,
   output logic      ext_clk
);
   logic [5:0] cnt_r = 6'h00;
   initial ext_clk = 1'b0;
   // Eight-cycle period, idle low between bursts
   always @(posedge aclk) begin
      cnt_r <= run ? cnt_r + 6'h01 : 6'h00;
      ext_clk <= run & cnt_r[2];
   end
endmodule

// File: verif/tic_timer_props.sv
`timescale 1ns/1ps
module tic_timer_props (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        dma_ack,
   input wire logic        timer_irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_rdata_hi;
      s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
   endproperty
   a_rdata_hi: assert property (p_rdata_hi) else $error("rdata upper half set");
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write answer not held");
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read answer not held");
   property p_bblk;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_bblk: assert property (p_bblk) else $error("write taken during answer");
   property p_rblk;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_rblk: assert property (p_rblk) else $error("read taken during answer");
   property p_rlat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rlat: assert property (p_rlat) else $error("read answer late");
   property p_bdone;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##0 s_axi_awready;
   endproperty
   a_bdone: assert property (p_bdone) else $error("write answer not closed");
   property p_irq_fall;
      $fell(timer_irq) && $past(aresetn) |-> $rose(s_axi_bvalid) || $past(dma_ack);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq dropped uncaused");
   c_irq: cover property ($rose(timer_irq));
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == tic_pkg::RESP_SLVERR);
   c_dma: cover property (dma_ack && timer_irq);
endmodule

bind tic_timer tic_timer_props tic_timer_props_i (
   .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .dma_ack, .timer_irq
);

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;
   typedef struct {logic [7:0] a; logic [31:0] e; logic [1:0] r;} tic_row_type;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        ext_run = 1'b0, src_cfg = 1'b0, pin_a = 1'b0, pin_b = 1'b0, dma = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, ext_clk, irq;
   logic [1:0]  bresp, rresp, rsp;
   logic [31:0] rdata, rd;
   int          error_cnt = 0, checks = 0, n;
   int          fac [3] = '{0, 3, 255};
   tic_row_type rows [5];
   always #10 aclk = ~aclk;
   tic_pins_model tic_pins_model_i (.aclk, .run(ext_run), .ext_clk);
   tic_timer tic_timer_i (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .ext_clock_input(ext_clk), .timer_source_config(src_cfg), .capture_pin_a(pin_a),
      .capture_pin_b(pin_b), .dma_ack(dma), .timer_irq(irq));
   task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
      checks++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge aclk);
      awaddr <= {24'h0, a};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      fork
         begin
            do @(posedge aclk); while (!awready);
            awvalid <= 1'b0;
         end
         begin
            do @(posedge aclk); while (!wready);
            wvalid <= 1'b0;
         end
      join
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
      rsp = bresp;
   endtask
   task automatic rdr(logic [7:0] a);
      @(posedge aclk);
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'b0;
      rd = rdata;
      rsp = rresp;
   endtask
   task automatic rchk(string nm, logic [7:0] a, logic [31:0] e);
      rdr(a);
      chk(nm, e, rd);
   endtask
   task automatic summarize;
      if (error_cnt == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      summarize;
   end
   initial begin
      rows = '{'{8'h00, 32'hf, 2'h0}, '{8'h04, 32'hfbff, 2'h0}, '{8'h10, 32'h0, 2'h0},
               '{8'h14, 32'h0, 2'h0}, '{8'h18, 32'h0, 2'h2}};
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rows[i]) begin
         rchk("reset value", rows[i].a, 32'h0);
         wr(rows[i].a, 32'hffffffff);
         chk("write resp", rows[i].r, rsp);
         rchk("readback", rows[i].a, rows[i].e);
         chk("read resp", rows[i].r, rsp);
      end
      wr(8'h00, 32'h0);
      foreach (fac[i]) begin
         wr(8'h04, {16'h0, 8'h20, 8'(fac[i])});
         wr(8'h08, 32'hffffdfff);
         wr(8'h0c, 32'h0);
         n = 0;
         while (!irq && n < 2000) begin
            @(posedge aclk);
            n++;
         end
         chk("rollover delay", 32'h1, 32'(n >= 3*fac[i]+4 && n <= 4*fac[i]+4));
      end
      wr(8'h04, 32'h000000ff);
      wr(8'h08, 32'hffffdfff);
      wr(8'h0c, 32'h0);
      repeat (1100) @(posedge aclk);
      chk("irq masked", 32'h0, {31'h0, irq});
      rchk("status", 8'h08, 32'h00002000);
      wr(8'h04, 32'h000020ff);
      @(posedge aclk);
      chk("irq pending", 32'h1, {31'h0, irq});
      wr(8'h08, 32'hffffffff);
      rchk("status keep", 8'h08, 32'h00002000);
      wr(8'h08, 32'hffffdfff);
      rchk("status clear", 8'h08, 32'h0);
      chk("irq clear", 32'h0, {31'h0, irq});
      wr(8'h00, 32'h7);
      wr(8'h04, 32'h8000);
      wr(8'h0c, 32'h0);
      pin_a <= 1'b1;
      repeat (6) @(posedge aclk);
      rchk("cap a", 8'h10, 32'h0000fffc);
      rchk("flags", 8'h08, 32'h00008000);
      chk("irq cap", 32'h1, {31'h0, irq});
      ext_run <= 1'b1;
      repeat (40) @(posedge aclk);
      ext_run <= 1'b0;
      repeat (6) @(posedge aclk);
      rchk("count ext", 8'h0c, 32'h00000001);
      pin_b <= 1'b1;
      repeat (6) @(posedge aclk);
      rchk("cap b rise", 8'h14, 32'h0);
      pin_b <= 1'b0;
      repeat (6) @(posedge aclk);
      rchk("cap b", 8'h14, 32'h00000001);
      wr(8'h04, 32'h00000100);
      dma <= 1'b1;
      @(posedge aclk);
      dma <= 1'b0;
      rchk("dma clear", 8'h08, 32'h0000b000 & 32'h00007000);
      wr(8'h08, 32'hffffefff);
      rchk("b clear", 8'h08, 32'h00002000);
      pin_a <= 1'b0;
      repeat (6) @(posedge aclk);
      src_cfg <= 1'b1;
      repeat (6) @(posedge aclk);
      pin_a <= 1'b1;
      repeat (6) @(posedge aclk);
      rchk("count pin a", 8'h0c, 32'h00000002);
      wr(8'h00, 32'h5);
      pin_a <= 1'b0;
      repeat (6) @(posedge aclk);
      rchk("count fall", 8'h0c, 32'h00000003);
      summarize;
   end
endmodule
